// ---- core/tdm_switch_pkg.sv ----
// Package with constants, state layout and pin bundle of the timeslot switch
// Functional notes
// - Eight inputs, 32 byte channels per frame
// - Any output channel takes any input channel
// - Host reads input bytes, writes output bytes
// - Open-drain acknowledge pulled low when done
// - Frame pulse low resets counter next fall
// - Bit cell spans two bit-clock cycles
// - Six address lines select the location
// - Data bus driven only during reads
// - Eight three-state serial outputs, 32 channels
// - Drive enable low floats all serial outputs
// - Per-channel config may float a channel
// - Control bit frame carries high entry bit 1
// - Address bit 5 low hits control register
// - Message bit sends low byte directly
// - Switched channel uses low byte as address
// - High entry bit 0 enables channel driver
package tdm_switch_pkg;

  // Frame geometry
  localparam int STREAMS = 8;
  localparam int CHANNELS = 32;
  localparam int ENTRIES = STREAMS * CHANNELS;
  localparam int HALF_CELLS = 512; // Bit clock falls per frame
  localparam int CNT_W = 9;

  // Host address layout
  localparam int ADDR_MEM_BIT = 5;

  // Control register fields
  localparam int CTRL_SPLIT_BIT = 7;
  localparam int CTRL_BCAST_BIT = 6;
  localparam int CTRL_MSEL_LSB = 3;
  localparam int CTRL_STREAM_LSB = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Memory select codes
  localparam logic [1:0] MSEL_NONE = 2'h0;
  localparam logic [1:0] MSEL_DATA = 2'h1;
  localparam logic [1:0] MSEL_CONN_LO = 2'h2;
  localparam logic [1:0] MSEL_CONN_HI = 2'h3;

  // Connection high entry bits
  localparam int CMH_OE_BIT = 0;
  localparam int CMH_CST_BIT = 1;
  localparam int CMH_MSG_BIT = 2;

  // Host access states
  typedef enum logic {HOST_IDLE, HOST_ACK} host_state_e;

  // Synchronised pin bundle
  typedef struct packed {
    logic output_drive_enable;
    logic [STREAMS-1:0] serial_in;
    logic [7:0] data;
    logic [5:0] addr;
    logic cs_n;
    logic rw;
    logic strobe;
    logic frame_n;
    logic bitclk;
  } pin_s;

  // Whole state of the switch
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic clk_d;
    logic [STREAMS-1:0][7:0] in_sr;
    logic [STREAMS-1:0][7:0] out_sr;
    logic [STREAMS-1:0] out_en;
    logic ctl_bit;
    logic [ENTRIES-1:0][7:0] dmem;
    logic [ENTRIES-1:0][7:0] cml;
    logic [ENTRIES-1:0][2:0] cmh;
    logic [7:0] ctrl;
    logic [7:0] rd_data;
    logic rd_oe;
    host_state_e hst;
  } switch_state_s;

  localparam switch_state_s STATE_RESET = '0;

endpackage

// ---- core/tdm_sync2.sv ----
// Two flip-flop synchroniser for a bundle of asynchronous inputs
`timescale 1ns/1ns
module tdm_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // Asynchronous inputs and their synchronised copy
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // Two stages; the first is only read by the second
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sync_state_s;

  sync_state_s st_reg;
  sync_state_s st_next;

  // Shift pins through both stages
  always_comb begin
    st_next = st_reg;
    st_next.meta = async_in;
    st_next.sync = st_reg.meta;
  end

  // State register
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.sync;

endmodule // tdm_sync2

// ---- core/tdm_timeslot_switch.sv ----
// Eight-stream timeslot switch with host access and control bit output
`timescale 1ns/1ns
module tdm_timeslot_switch (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // Serial timing pins
  input wire logic bit_clock_4m_in,
  input wire logic frame_pulse_n_in,
  // Serial streams
  input wire logic [7:0] serial_in,
  output logic [7:0] serial_out_out,
  output logic [7:0] serial_oe_out,
  input wire logic output_drive_enable_in,
  output logic control_bit_out,
  // Host interface
  input wire logic data_strobe_in,
  input wire logic read_write_in,
  input wire logic chip_select_n_in,
  input wire logic [5:0] host_addr_in,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe_out,
  output logic transfer_ack_n_out,
  output logic transfer_ack_oe_out
);

  // Synchronised pins
  logic [$bits(tdm_switch_pkg::pin_s)-1:0] sync_bits;
  tdm_switch_pkg::pin_s pin;

  // State copy and its register
  tdm_switch_pkg::switch_state_s st_reg;
  tdm_switch_pkg::switch_state_s st_next;

  // Frame timing helpers
  logic fall; // Falling edge of the bit clock seen
  logic [8:0] cnt_new; // Count after this falling edge
  logic boundary; // Bit cell boundary edge
  logic mid_cell; // Sampling edge in the middle of a cell
  logic [4:0] chan_new; // Channel of the new count
  logic [2:0] bit_new; // Bit slot of the new count, 0 is msb
  logic [4:0] chan_ahead; // Channel one ahead for control bits

  // Host decode helpers
  logic access; // Selected and strobed
  logic [7:0] mem_idx; // Stream and channel index of the access
  logic bcast; // Broadcast message mode
  logic split; // Split memory mode
  logic [1:0] msel; // Memory select field
  logic [7:0] rd_mux; // Read data picked by the decode

  // Stream 0 helpers for load and sample checking, and the next control bit
  logic msg0;
  logic oe0;
  logic [7:0] cml0;
  logic [7:0] sw0;
  logic cst_next;
  logic [7:0] sample0;

  // Bring all pins into the clock domain
  tdm_sync2 #(
    .WIDTH($bits(tdm_switch_pkg::pin_s))
  ) u_sync (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .async_in({output_drive_enable_in, serial_in, host_data_in, host_addr_in, chip_select_n_in,
      read_write_in, data_strobe_in, frame_pulse_n_in, bit_clock_4m_in}),
    .sync_out(sync_bits)
  );

  assign pin = tdm_switch_pkg::pin_s'(sync_bits);

  // Edge and counter decode
  assign fall = st_reg.clk_d & ~pin.bitclk;
  assign cnt_new = pin.frame_n ? 9'(st_reg.cnt + 9'h001) : 9'h000;
  assign boundary = fall & ~cnt_new[0];
  assign mid_cell = fall & cnt_new[0];
  assign chan_new = cnt_new[8:4];
  assign bit_new = cnt_new[3:1];
  assign chan_ahead = 5'(chan_new + 5'h01);

  // Control register fields
  assign bcast = st_reg.ctrl[tdm_switch_pkg::CTRL_BCAST_BIT];
  assign split = st_reg.ctrl[tdm_switch_pkg::CTRL_SPLIT_BIT];
  assign msel = st_reg.ctrl[tdm_switch_pkg::CTRL_MSEL_LSB +: 2];

  // Host access qualification
  assign access = pin.strobe & ~pin.cs_n;
  assign mem_idx = {st_reg.ctrl[tdm_switch_pkg::CTRL_STREAM_LSB +: 3], pin.addr[4:0]};

  // Stream 0 views of the load and sample paths, and the next control bit
  assign cml0 = st_reg.cml[{3'h0, chan_new}];
  assign sw0 = st_reg.dmem[cml0];
  assign msg0 = bcast | st_reg.cmh[{3'h0, chan_new}][tdm_switch_pkg::CMH_MSG_BIT];
  assign oe0 = bcast | st_reg.cmh[{3'h0, chan_new}][tdm_switch_pkg::CMH_OE_BIT];
  assign cst_next = st_reg.cmh[{bit_new, chan_ahead}][tdm_switch_pkg::CMH_CST_BIT];
  assign sample0 = {st_reg.in_sr[0][6:0], pin.serial_in[0]};

  // Read data selection
  always_comb begin
    rd_mux = 8'h00;
    if (!pin.addr[tdm_switch_pkg::ADDR_MEM_BIT]) begin
      rd_mux = st_reg.ctrl;
    end else if (split) begin
      rd_mux = st_reg.dmem[mem_idx];
    end else if (msel == tdm_switch_pkg::MSEL_DATA) begin
      rd_mux = st_reg.dmem[mem_idx];
    end else if (msel == tdm_switch_pkg::MSEL_CONN_LO) begin
      rd_mux = st_reg.cml[mem_idx];
    end else if (msel == tdm_switch_pkg::MSEL_CONN_HI) begin
      rd_mux = {5'h00, st_reg.cmh[mem_idx]};
    end else begin
      rd_mux = 8'h00;
    end
  end

  // Next state of the whole switch
  always_comb begin
    st_next = st_reg;
    st_next.clk_d = pin.bitclk;
    // Serial frame timing
    if (fall) begin
      st_next.cnt = cnt_new;
    end
    // Input sampling in the middle of each cell
    if (mid_cell) begin
      for (int s = 0; s < tdm_switch_pkg::STREAMS; s++) begin
        st_next.in_sr[s] = {st_reg.in_sr[s][6:0], pin.serial_in[s]};
        if (bit_new == 3'h7) begin
          st_next.dmem[{3'(s), chan_new}] = {st_reg.in_sr[s][6:0], pin.serial_in[s]};
        end
      end
    end
    // Output load or shift at each cell boundary
    if (boundary) begin
      st_next.ctl_bit = cst_next;
      for (int s = 0; s < tdm_switch_pkg::STREAMS; s++) begin
        if (bit_new == 3'h0) begin
          // Message channels send the low byte, others the switched byte
          if (bcast | st_reg.cmh[{3'(s), chan_new}][tdm_switch_pkg::CMH_MSG_BIT]) begin
            st_next.out_sr[s] = st_reg.cml[{3'(s), chan_new}];
          end else begin
            st_next.out_sr[s] = st_reg.dmem[st_reg.cml[{3'(s), chan_new}]];
          end
          st_next.out_en[s] = bcast | st_reg.cmh[{3'(s), chan_new}][tdm_switch_pkg::CMH_OE_BIT];
        end else begin
          st_next.out_sr[s] = {st_reg.out_sr[s][6:0], 1'b0};
        end
      end
    end
    // Host access sequencing
    case (st_reg.hst)
      tdm_switch_pkg::HOST_IDLE: begin
        if (access) begin
          st_next.hst = tdm_switch_pkg::HOST_ACK;
          if (pin.rw) begin
            // Read: capture and drive the bus
            st_next.rd_data = rd_mux;
            st_next.rd_oe = 1'b1;
          end else if (!pin.addr[tdm_switch_pkg::ADDR_MEM_BIT]) begin
            st_next.ctrl = pin.data;
          end else if (split || msel == tdm_switch_pkg::MSEL_CONN_LO) begin
            st_next.cml[mem_idx] = pin.data;
          end else if (msel == tdm_switch_pkg::MSEL_CONN_HI) begin
            st_next.cmh[mem_idx] = pin.data[2:0];
          end else begin
            // Data memory is not host writable
            st_next.rd_oe = 1'b0;
          end
        end
      end
      tdm_switch_pkg::HOST_ACK: begin
        // Hold acknowledge until the strobe or select goes away
        if (!access) begin
          st_next.hst = tdm_switch_pkg::HOST_IDLE;
          st_next.rd_oe = 1'b0;
        end
      end
      default: begin
        st_next.hst = tdm_switch_pkg::HOST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_reg <= tdm_switch_pkg::STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Serial output pins
  genvar g;
  generate
    for (g = 0; g < tdm_switch_pkg::STREAMS; g++) begin : g_out
      assign serial_out_out[g] = st_reg.out_sr[g][7];
    end
  endgenerate

  assign serial_oe_out = st_reg.out_en & {8{pin.output_drive_enable}};
  assign control_bit_out = st_reg.ctl_bit;

  // Host pins
  assign host_data_out = st_reg.rd_data;
  assign host_data_oe_out = st_reg.rd_oe;
  assign transfer_ack_n_out = 1'b0;
  assign transfer_ack_oe_out = (st_reg.hst == tdm_switch_pkg::HOST_ACK);

  // Checks of the serial timing
  property p_frame_reset;
    @(posedge clock_in) disable iff (!rst_b_in)
    (fall && !pin.frame_n) |=> (st_reg.cnt == 9'h000);
  endproperty
  a_frame_reset: assert property (p_frame_reset) else $error("counter not cleared by frame pulse");

  property p_count_step;
    @(posedge clock_in) disable iff (!rst_b_in)
    (fall && pin.frame_n) |=> (st_reg.cnt == 9'($past(st_reg.cnt) + 9'h001));
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not step");

  property p_out_cell;
    @(posedge clock_in) disable iff (!rst_b_in)
    $changed(serial_out_out) |-> $past(boundary);
  endproperty
  a_out_cell: assert property (p_out_cell) else $error("serial output moved off a cell boundary");

  property p_ode_off;
    @(posedge clock_in) disable iff (!rst_b_in)
    !pin.output_drive_enable |-> (serial_oe_out == 8'h00);
  endproperty
  a_ode_off: assert property (p_ode_off) else $error("serial output driven with drive enable low");

  property p_dmem_store;
    @(posedge clock_in) disable iff (!rst_b_in)
    (mid_cell && bit_new == 3'h7) |=> (st_reg.dmem[{3'h0, $past(chan_new)}] == $past(sample0));
  endproperty
  a_dmem_store: assert property (p_dmem_store) else $error("input byte not stored");

  // Checks of the output load
  sequence s_load0;
    boundary && bit_new == 3'h0;
  endsequence

  property p_msg_load;
    @(posedge clock_in) disable iff (!rst_b_in)
    (s_load0 and msg0) |=> (st_reg.out_sr[0] == $past(cml0));
  endproperty
  a_msg_load: assert property (p_msg_load) else $error("message byte not loaded");

  property p_switch_load;
    @(posedge clock_in) disable iff (!rst_b_in)
    (s_load0 and !msg0) |=> (st_reg.out_sr[0] == $past(sw0));
  endproperty
  a_switch_load: assert property (p_switch_load) else $error("switched byte not loaded");

  property p_chan_off;
    @(posedge clock_in) disable iff (!rst_b_in)
    (s_load0 and !oe0) |=> !serial_oe_out[0];
  endproperty
  a_chan_off: assert property (p_chan_off) else $error("disabled channel driven");

  property p_cst;
    @(posedge clock_in) disable iff (!rst_b_in)
    boundary |=> (control_bit_out == $past(cst_next));
  endproperty
  a_cst: assert property (p_cst) else $error("control bit wrong");

  // Checks of the host handshake
  sequence s_access_begin;
    (st_reg.hst == tdm_switch_pkg::HOST_IDLE) && access;
  endsequence

  sequence s_access_end;
    (st_reg.hst == tdm_switch_pkg::HOST_ACK) && !access;
  endsequence

  property p_ack_set;
    @(posedge clock_in) disable iff (!rst_b_in)
    s_access_begin |=> transfer_ack_oe_out && !transfer_ack_n_out;
  endproperty
  a_ack_set: assert property (p_ack_set) else $error("acknowledge missing");

  property p_ack_release;
    @(posedge clock_in) disable iff (!rst_b_in)
    s_access_end |=> !transfer_ack_oe_out && !host_data_oe_out;
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("acknowledge not released");

  property p_cs_ignored;
    @(posedge clock_in) disable iff (!rst_b_in)
    ((st_reg.hst == tdm_switch_pkg::HOST_IDLE) && pin.cs_n) |=> !transfer_ack_oe_out;
  endproperty
  a_cs_ignored: assert property (p_cs_ignored) else $error("deselected access answered");

  property p_read_drive;
    @(posedge clock_in) disable iff (!rst_b_in)
    (s_access_begin and pin.rw) |=> host_data_oe_out && (host_data_out == $past(rd_mux));
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read data not driven");

  property p_ctrl_write;
    @(posedge clock_in) disable iff (!rst_b_in)
    (s_access_begin and !pin.rw && !pin.addr[tdm_switch_pkg::ADDR_MEM_BIT]) |=> (st_reg.ctrl == $past(pin.data));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control register not written");

  // Connection low writes land at the decoded entry, split mode included
  property p_cml_write;
    @(posedge clock_in) disable iff (!rst_b_in)
    (s_access_begin and !pin.rw && pin.addr[tdm_switch_pkg::ADDR_MEM_BIT]
      && (split || msel == tdm_switch_pkg::MSEL_CONN_LO)) |=> (st_reg.cml[$past(mem_idx)] == $past(pin.data));
  endproperty
  a_cml_write: assert property (p_cml_write) else $error("connection low not written");

  // Acknowledge stays while the strobe and select stay
  property p_ack_hold;
    @(posedge clock_in) disable iff (!rst_b_in)
    ((st_reg.hst == tdm_switch_pkg::HOST_ACK) && access) |=> transfer_ack_oe_out;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("acknowledge dropped early");

  // Counter only moves on a detected falling edge
  property p_cnt_hold;
    @(posedge clock_in) disable iff (!rst_b_in)
    !fall |=> $stable(st_reg.cnt);
  endproperty
  a_cnt_hold: assert property (p_cnt_hold) else $error("counter moved without a bit clock fall");

  // Stream 0 input shift register takes one bit per sample point
  property p_in_shift;
    @(posedge clock_in) disable iff (!rst_b_in)
    mid_cell |=> (st_reg.in_sr[0] == $past(sample0));
  endproperty
  a_in_shift: assert property (p_in_shift) else $error("input bit not shifted in");

  // Stream 0 output shifts by one bit at the other boundaries
  property p_out_shift;
    @(posedge clock_in) disable iff (!rst_b_in)
    (boundary && bit_new != 3'h0) |=> (st_reg.out_sr[0] == {$past(st_reg.out_sr[0][6:0]), 1'b0});
  endproperty
  a_out_shift: assert property (p_out_shift) else $error("output bit not shifted out");

  // Enabled channel drives while the drive enable is high
  property p_drive_on;
    @(posedge clock_in) disable iff (!rst_b_in)
    (s_load0 and oe0) ##1 pin.output_drive_enable |-> serial_oe_out[0];
  endproperty
  a_drive_on: assert property (p_drive_on) else $error("enabled channel not driven");

endmodule // tdm_timeslot_switch

// ---- verif/tdm_stream_model.sv ----
// Serial partner: bit clock, frame pulse, input streams and capture of the outputs
`timescale 1ns/1ns
module tdm_stream_model (
  // Timing pins toward the switch
  output logic bit_clock_4m_out,
  output logic frame_pulse_n_out,
  // Streams toward and from the switch
  output logic [7:0] serial_in_out,
  input wire logic [7:0] serial_out_in,
  input wire logic [7:0] serial_oe_in,
  input wire logic control_bit_in
);
  logic [8:0] cnt_reg; // Half cells since the frame started
  logic [7:0] pat; // Byte sent on the current channel
  logic [7:0][7:0] sh; // Output shift registers
  logic [7:0][31:0][7:0] rx_byte; // Last byte seen per output channel
  logic [7:0][31:0] rx_oe; // Driver enable at the end of each channel
  logic [255:0] ctl_bits; // Last control bit frame

  // Free-running bit clock, phase unrelated to the system clock
  initial begin
    cnt_reg = 9'h1FF;
    sh = '0;
    frame_pulse_n_out = 1'b1;
    bit_clock_4m_out = 1'b1;
    #7;
    forever #80 bit_clock_4m_out = ~bit_clock_4m_out;
  end

  // Frame pulse low across the fall that starts count 0
  always @(posedge bit_clock_4m_out) begin
    frame_pulse_n_out <= (cnt_reg != 9'h1FF);
  end

  // Input byte of stream s, channel c is the inverse of {s, c}, bit 7 first
  always_comb begin
    for (int s = 0; s < 8; s++) begin
      pat = ~{3'(s), cnt_reg[8:4]};
      serial_in_out[s] = pat[3'h7 - cnt_reg[3:1]];
    end
  end

  // Capture outputs at the middle of every bit cell
  always @(negedge bit_clock_4m_out) begin
    cnt_reg = cnt_reg + 9'h001;
    if (cnt_reg[0]) begin
      ctl_bits[cnt_reg[8:1]] = control_bit_in;
      for (int s = 0; s < 8; s++) begin
        sh[s] = {sh[s][6:0], serial_out_in[s]};
        // Last bit of the channel: keep the byte and the drive state
        if (cnt_reg[3:0] == 4'hF) begin
          rx_byte[s][cnt_reg[8:4]] = sh[s];
          rx_oe[s][cnt_reg[8:4]] = serial_oe_in[s];
        end
      end
    end
  end
endmodule // tdm_stream_model

// ---- verif/tb.sv ----
// Self-checking bench for the timeslot switch: host accesses and serial frames
`timescale 1ns/1ns
module tb;
  logic clock_in, rst_b_in; // System clock and reset
  logic bclk, frame_n, output_drive_enable, ctl; // Serial timing and control pins
  logic [7:0] sin, sout, soe; // Serial streams
  logic strobe, rw, cs_n; // Host strobes
  logic [5:0] addr; // Host address
  logic [7:0] wdata, rdata, q; // Host data and last read
  logic data_oe, ack_n, ack_oe; // Host outputs
  wire ack_w = ack_oe ? ack_n : 1'b1; // Open-drain line with pull-up
  int err_total, samples_checked; // Mismatch and comparison counters

  tdm_timeslot_switch i_dut (.clock_in(clock_in), .rst_b_in(rst_b_in), .bit_clock_4m_in(bclk),
    .frame_pulse_n_in(frame_n), .serial_in(sin), .serial_out_out(sout), .serial_oe_out(soe),
    .output_drive_enable_in(output_drive_enable), .control_bit_out(ctl), .data_strobe_in(strobe),
    .read_write_in(rw), .chip_select_n_in(cs_n), .host_addr_in(addr), .host_data_in(wdata),
    .host_data_out(rdata), .host_data_oe_out(data_oe), .transfer_ack_n_out(ack_n),
    .transfer_ack_oe_out(ack_oe));

  tdm_stream_model i_model (.bit_clock_4m_out(bclk), .frame_pulse_n_out(frame_n),
    .serial_in_out(sin), .serial_out_in(sout), .serial_oe_in(soe), .control_bit_in(ctl));

  // 50 MHz system clock
  always #10 clock_in = ~clock_in;

  // Count totals, print the verdict and stop
  task results();
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Compare one value and report a mismatch
  task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask

  // One host access: strobe held until acknowledge, released until ack clears
  task acc(input logic rd, input logic [5:0] a, input logic [7:0] d, input logic sel_n);
    int n;
    @(posedge clock_in);
    strobe <= 1'b1;
    rw <= rd;
    cs_n <= sel_n;
    addr <= a;
    wdata <= d;
    n = 0;
    while (ack_w !== 1'b0 && n < 40) begin
      @(negedge clock_in);
      n++;
    end
    if (sel_n) chk("ignored ack", 8'h01, {7'h00, ack_w});
    else chk("ack low", 8'h00, {7'h00, ack_w});
    if (!sel_n && n == 40) results();
    q = rdata;
    chk("data drive", {7'h00, rd & ~sel_n}, {7'h00, data_oe});
    @(posedge clock_in);
    strobe <= 1'b0;
    cs_n <= 1'b1;
    n = 0;
    while (ack_w !== 1'b1 && n < 40) begin
      @(negedge clock_in);
      n++;
    end
    chk("ack release", 8'h01, {7'h00, ack_w});
    if (n == 40) results();
  endtask

  initial begin
    clock_in = 1'b0;
    rst_b_in = 1'b0;
    output_drive_enable = 1'b1;
    strobe = 1'b0;
    rw = 1'b1;
    cs_n = 1'b1;
    addr = 6'h00;
    wdata = 8'h00;
    err_total = 0;
    samples_checked = 0;
    repeat (5) @(posedge clock_in);
    rst_b_in <= 1'b1;
    chk("reset ack", 8'h01, {7'h00, ack_w});
    chk("reset drive", 8'h00, soe);
    $display("Test reset done");
    // Control register reached at any address with bit 5 low
    acc(1'b0, 6'h1F, 8'h55, 1'b0);
    acc(1'b1, 6'h02, 8'h00, 1'b0);
    chk("control", 8'h55, q);
    acc(1'b0, 6'h00, 8'hAA, 1'b1);
    acc(1'b1, 6'h1F, 8'h00, 1'b0);
    chk("control kept", 8'h55, q);
    $display("Test control done");
    // Stream 1 ch 3 message byte; stream 2 ch 5 switched from stream 4 ch 9
    acc(1'b0, 6'h00, 8'h11, 1'b0);
    acc(1'b0, 6'h23, 8'hA5, 1'b0);
    acc(1'b0, 6'h00, 8'h12, 1'b0);
    acc(1'b0, 6'h25, 8'h89, 1'b0);
    acc(1'b0, 6'h00, 8'h19, 1'b0);
    acc(1'b0, 6'h23, 8'h07, 1'b0);
    acc(1'b0, 6'h00, 8'h1A, 1'b0);
    acc(1'b0, 6'h25, 8'h01, 1'b0);
    acc(1'b1, 6'h25, 8'h00, 1'b0);
    chk("high entry", 8'h01, q);
    repeat (9000) @(posedge clock_in);
    chk("message", 8'hA5, i_model.rx_byte[1][3]);
    chk("switched", 8'h76, i_model.rx_byte[2][5]);
    chk("drive on", 8'h01, {7'h00, i_model.rx_oe[2][5]});
    chk("drive off", 8'h00, {7'h00, i_model.rx_oe[0][0]});
    chk("ctl set", 8'h01, {7'h00, i_model.ctl_bits[17]});
    chk("ctl clear", 8'h00, {7'h00, i_model.ctl_bits[18]});
    $display("Test switching done");
    // Received byte of stream 6 ch 7 read back from data memory
    acc(1'b0, 6'h00, 8'h0E, 1'b0);
    acc(1'b1, 6'h27, 8'h00, 1'b0);
    chk("data memory", 8'h38, q);
    // Split mode reads data memory and writes connection low
    acc(1'b0, 6'h00, 8'h86, 1'b0);
    acc(1'b1, 6'h27, 8'h00, 1'b0);
    chk("split read", 8'h38, q);
    acc(1'b0, 6'h27, 8'h5A, 1'b0);
    acc(1'b0, 6'h00, 8'h16, 1'b0);
    acc(1'b1, 6'h27, 8'h00, 1'b0);
    chk("split write", 8'h5A, q);
    $display("Test data memory done");
    // Broadcast enables every channel, drive enable low floats all
    acc(1'b0, 6'h00, 8'h40, 1'b0);
    acc(1'b1, 6'h20, 8'h00, 1'b0);
    chk("no memory", 8'h00, q);
    repeat (4400) @(posedge clock_in);
    chk("broadcast drive", 8'h01, {7'h00, i_model.rx_oe[0][0]});
    chk("broadcast byte", 8'h89, i_model.rx_byte[2][5]);
    output_drive_enable <= 1'b0;
    repeat (4200) @(posedge clock_in);
    chk("float all", 8'h00, soe);
    chk("float msg", 8'h00, {7'h00, i_model.rx_oe[1][3]});
    $display("Test drive enable done");
    results();
  end
endmodule // tb
